// *** hw/twslv_top.sv ***
// two-wire slave receiver with apb register access
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns

module twslv_top
  import twslv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // two-wire bus pins
  input wire logic I_SCL_IN,
  output logic O_SCL_OUT,
  output logic O_SCL_OE,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // power and master section
  input wire logic I_SLEEP,
  input wire logic I_ARB_LOST,
  output logic O_WAKE,
  output logic O_START_REQ,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  twslv_ctrl_t ctrl;
  twslv_phase_t phase, resume_phase;
  logic [7:0] own_slave_address, bus_state, byte_buffer, shifter, rx_byte, ctrl_read;
  logic [PRESC_MSB:0] prescaler;
  logic [1:0] scl_sync, sda_sync;
  logic [3:0] bit_count;
  logic [31:0] next_rdata;
  logic interrupt_flag, write_collision_flag, scl_prev, sda_prev, got_rise, acked, gc_mode;
  logic addressed, bus_free, sda_drive, flag_set, wake_hold, start_req, buffer_load;
  logic wr_access, rd_setup, hit_osa, hit_ctrl, hit_stat, hit_data, mapped, clear_flag;
  logic scl_rise, scl_fall, start_cond, stop_cond, own_match, gc_match;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // writes land at the access edge; reads are captured at setup
  assign wr_access = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_setup = I_PSEL & ~I_PENABLE;
  assign hit_osa = I_PADDR == ADDR_W'(OFS_OWN_SLAVE_ADDRESS);
  assign hit_ctrl = I_PADDR == ADDR_W'(OFS_INTERFACE_CONTROL);
  assign hit_stat = I_PADDR == ADDR_W'(OFS_BUS_STATE_REGISTER);
  assign hit_data = I_PADDR == ADDR_W'(OFS_BYTE_BUFFER_REGISTER);
  assign mapped = hit_osa | hit_ctrl | hit_stat | hit_data;
  // flag clears by writing one to it
  assign clear_flag = I_CE & wr_access & hit_ctrl & I_PWDATA[BIT_INTERRUPT_FLAG];
  // zero wait states: every access phase completes at once
  assign O_PREADY = 1'b1;

  // control register image, unused bit reads zero
  always_comb begin
    ctrl_read = 8'h00;
    ctrl_read[BIT_INTERRUPT_FLAG] = interrupt_flag;
    ctrl_read[BIT_ACKNOWLEDGE_ENABLE] = ctrl.acknowledge_enable;
    ctrl_read[BIT_BEGIN_REQUEST] = ctrl.begin_condition_request;
    ctrl_read[BIT_HALT_REQUEST] = ctrl.halt_condition_request;
    ctrl_read[BIT_WRITE_COLLISION] = write_collision_flag;
    ctrl_read[BIT_INTERFACE_ENABLE] = ctrl.interface_enable;
    ctrl_read[BIT_INTERRUPT_ENABLE] = ctrl.interrupt_enable;
  end

  // read mux; narrow registers sit in the low byte
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_osa) begin
      next_rdata[7:0] = own_slave_address;
    end else if (hit_ctrl) begin
      next_rdata[7:0] = ctrl_read;
    end else if (hit_stat) begin
      next_rdata[7:0] = {bus_state[7:3], 1'b0, prescaler};
    end else if (hit_data) begin
      next_rdata[7:0] = byte_buffer;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else if (I_CE && rd_setup) begin
      O_PRDATA <= I_PWRITE ? 32'h0000_0000 : next_rdata;
      O_PSLVERR <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // own address register and prescaler
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      own_slave_address <= RST_OWN_SLAVE_ADDRESS;
      prescaler <= RST_PRESCALER;
    end else if (I_CE && wr_access) begin
      if (hit_osa) begin
        own_slave_address <= I_PWDATA[7:0];
      end
      // prescaler kept apart from the code bits
      if (hit_stat) begin
        prescaler <= I_PWDATA[PRESC_MSB:0];
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl <= '0;
    end else if (I_CE && wr_access && hit_ctrl) begin
      ctrl.acknowledge_enable <= I_PWDATA[BIT_ACKNOWLEDGE_ENABLE];
      ctrl.begin_condition_request <= I_PWDATA[BIT_BEGIN_REQUEST];
      ctrl.halt_condition_request <= I_PWDATA[BIT_HALT_REQUEST];
      ctrl.interface_enable <= I_PWDATA[BIT_INTERFACE_ENABLE];
      ctrl.interrupt_enable <= I_PWDATA[BIT_INTERRUPT_ENABLE];
    end
  end

  // flag: a hardware set beats a software clear in the same cycle
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      interrupt_flag <= 1'b0;
    end else if (I_CE) begin
      if (flag_set) begin
        interrupt_flag <= 1'b1;
      end else if (clear_flag) begin
        interrupt_flag <= 1'b0;
      end
    end
  end

  // byte buffer: received bytes, or software writes while flag is set
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      byte_buffer <= RST_BYTE_BUFFER;
      write_collision_flag <= 1'b0;
    end else if (I_CE) begin
      if (buffer_load) begin
        byte_buffer <= rx_byte;
      end else if (wr_access && hit_data) begin
        // writing while the flag is clear is a collision, data dropped
        if (interrupt_flag) begin
          byte_buffer <= I_PWDATA[7:0];
          write_collision_flag <= 1'b0;
        end else begin
          write_collision_flag <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // two stages before any logic looks at the pins
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (I_CE) begin
      scl_sync <= {scl_sync[0], I_SCL_IN};
      sda_sync <= {sda_sync[0], I_SDA_IN};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // seven address bits plus write direction
  assign own_match = (shifter[7:1] == own_slave_address[7:1]) & ~shifter[0];
  assign gc_match = (shifter == BROADCAST_ADDRESS) & own_slave_address[BIT_BROADCAST_ENABLE];

  // bus busy tracking for a pending begin request
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      bus_free <= 1'b1;
    end else if (I_CE && (start_cond || stop_cond)) begin
      // start and stop never coincide, so stop alone decides
      bus_free <= stop_cond;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      phase <= PH_IDLE;
      resume_phase <= PH_IDLE;
      shifter <= 8'h00;
      bit_count <= 4'h0;
      got_rise <= 1'b0;
      acked <= 1'b0;
      gc_mode <= 1'b0;
      addressed <= 1'b0;
      sda_drive <= 1'b0;
      flag_set <= 1'b0;
      bus_state <= STA_NO_INFO;
      buffer_load <= 1'b0;
      rx_byte <= 8'h00;
      wake_hold <= 1'b0;
    end else if (I_CE) begin
      flag_set <= 1'b0;
      buffer_load <= 1'b0;
      // wake stays up until software clears the flag
      if (clear_flag && !flag_set) begin
        wake_hold <= 1'b0;
      end
      if (!ctrl.interface_enable) begin
        phase <= PH_IDLE;
        sda_drive <= 1'b0;
        addressed <= 1'b0;
      end else if (phase != PH_HOLD && (start_cond || stop_cond)) begin
        sda_drive <= 1'b0;
        bit_count <= 4'h0;
        got_rise <= 1'b0;
        if (addressed) begin
          // end of an addressed transfer is reported
          addressed <= 1'b0;
          flag_set <= 1'b1;
          bus_state <= STA_END_ADDRESSED;
          phase <= PH_HOLD;
          resume_phase <= start_cond ? PH_ADDR : PH_IDLE;
        end else begin
          // bus still watched while acknowledge is off
          phase <= start_cond ? PH_ADDR : PH_IDLE;
        end
      end else begin
        case (phase)
          PH_IDLE, PH_SKIP: begin
            sda_drive <= 1'b0;
          end
          PH_ADDR: begin
            if (scl_rise) begin
              shifter <= {shifter[6:0], sda_sync[1]};
              bit_count <= bit_count + 4'h1;
            end else if (scl_fall && bit_count == BITS_PER_BYTE) begin
              // ack own or broadcast address only with acknowledge on
              if (ctrl.acknowledge_enable && (own_match || gc_match)) begin
                sda_drive <= 1'b1;
                gc_mode <= gc_match;
                got_rise <= 1'b0;
                phase <= PH_AACK;
              end else begin
                // read direction or foreign address: not for us
                phase <= PH_SKIP;
              end
            end
          end
          PH_AACK: begin
            if (scl_rise) begin
              got_rise <= 1'b1;
            end else if (scl_fall && got_rise) begin
              sda_drive <= 1'b0;
              addressed <= 1'b1;
              // flag and status after address and write bit
              flag_set <= 1'b1;
              phase <= PH_HOLD;
              resume_phase <= PH_DATA;
              wake_hold <= I_SLEEP;
              // lost arbitration selects the alternate codes
              if (gc_mode) begin
                bus_state <= I_ARB_LOST ? STA_GEN_CALL_ARB : STA_GEN_CALL;
              end else begin
                bus_state <= I_ARB_LOST ? STA_OWN_ADDR_ARB : STA_OWN_ADDR;
              end
            end
          end
          PH_HOLD: begin
            // entered before the flag is set, so left a cycle later; the flag alone keeps scl low
            if (!interrupt_flag) begin
              phase <= resume_phase;
              bit_count <= 4'h0;
              got_rise <= 1'b0;
            end
          end
          PH_DATA: begin
            if (scl_rise) begin
              shifter <= {shifter[6:0], sda_sync[1]};
              bit_count <= bit_count + 4'h1;
            end else if (scl_fall && bit_count == BITS_PER_BYTE) begin
              // byte buffer left alone while asleep
              buffer_load <= ~I_SLEEP;
              rx_byte <= shifter;
              // ack follows the enable at the byte's end
              sda_drive <= ctrl.acknowledge_enable;
              acked <= ctrl.acknowledge_enable;
              got_rise <= 1'b0;
              phase <= PH_DACK;
            end
          end
          PH_DACK: begin
            if (scl_rise) begin
              got_rise <= 1'b1;
            end else if (scl_fall && got_rise) begin
              sda_drive <= 1'b0;
              flag_set <= 1'b1;
              phase <= PH_HOLD;
              // acked byte continues, nacked byte ends it
              if (acked) begin
                bus_state <= gc_mode ? STA_GC_DATA_ACK : STA_DATA_ACK;
                resume_phase <= PH_DATA;
              end else begin
                bus_state <= gc_mode ? STA_GC_DATA_NACK : STA_DATA_NACK;
                resume_phase <= PH_IDLE;
                addressed <= 1'b0;
              end
            end
          end
          default: begin
            phase <= PH_IDLE;
          end
        endcase
      end
    end
  end

  // begin request issued once unaddressed and the bus is free
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      start_req <= 1'b0;
    end else if (I_CE) begin
      start_req <= ctrl.interface_enable & ctrl.begin_condition_request & bus_free &
                   ~addressed & (phase == PH_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain pins only ever pull low
  assign O_SCL_OUT = 1'b0;
  assign O_SDA_OUT = 1'b0;
  // stretch scl while the flag waits
  assign O_SCL_OE = interrupt_flag & ctrl.interface_enable;
  assign O_SDA_OE = sda_drive;
  // wake request for the power controller
  assign O_WAKE = wake_hold;
  assign O_START_REQ = start_req;
  assign O_IRQ = interrupt_flag & ctrl.interrupt_enable;

endmodule

// *** hw/twslv_pkg.sv ***
// shared constants and types for the two-wire slave receiver
package twslv_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the apb bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OWN_SLAVE_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_INTERFACE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BUS_STATE_REGISTER = 8'h08;
  localparam logic [7:0] OFS_BYTE_BUFFER_REGISTER = 8'h0C;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OWN_SLAVE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_BYTE_BUFFER = 8'hFF;
  localparam logic [1:0] RST_PRESCALER = 2'h0;

  // ----------------------------------------------------------------
  // interface_control bit positions, plus the own-address broadcast bit and prescaler msb
  // ----------------------------------------------------------------
  localparam int BIT_INTERRUPT_FLAG = 7;
  localparam int BIT_ACKNOWLEDGE_ENABLE = 6;
  localparam int BIT_BEGIN_REQUEST = 5;
  localparam int BIT_HALT_REQUEST = 4;
  localparam int BIT_WRITE_COLLISION = 3;
  localparam int BIT_INTERFACE_ENABLE = 2;
  localparam int BIT_INTERRUPT_ENABLE = 0;
  localparam int BIT_BROADCAST_ENABLE = 0;
  localparam int PRESC_MSB = 1;

  // ----------------------------------------------------------------
  // status codes, prescaler bits zero
  // ----------------------------------------------------------------
  localparam logic [7:0] STA_OWN_ADDR = 8'h60;
  localparam logic [7:0] STA_OWN_ADDR_ARB = 8'h68;
  localparam logic [7:0] STA_GEN_CALL = 8'h70;
  localparam logic [7:0] STA_GEN_CALL_ARB = 8'h78;
  localparam logic [7:0] STA_DATA_ACK = 8'h80;
  localparam logic [7:0] STA_DATA_NACK = 8'h88;
  localparam logic [7:0] STA_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] STA_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] STA_END_ADDRESSED = 8'hA0;
  localparam logic [7:0] STA_NO_INFO = 8'hF8;
  localparam logic [7:0] BROADCAST_ADDRESS = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // control bits held by software
  typedef struct packed {
    logic acknowledge_enable;
    logic begin_condition_request;
    logic halt_condition_request;
    logic interface_enable;
    logic interrupt_enable;
  } twslv_ctrl_t;

  // bus sequencer phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_AACK = 3'b010,
    PH_HOLD = 3'b011,
    PH_DATA = 3'b100,
    PH_DACK = 3'b101,
    PH_SKIP = 3'b110
  } twslv_phase_t;

endpackage

// *** dv/twslv_props.sv ***
// port-level checks for the two-wire slave receiver
`timescale 1ns/1ns
module twslv_props
  import twslv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  // apb
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic O_PSLVERR,
  // bus and status
  input wire logic I_SCL_IN,
  input wire logic I_SLEEP,
  input wire logic O_SCL_OE,
  input wire logic O_SDA_OE,
  input wire logic O_WAKE,
  input wire logic O_IRQ
);
  // control write at the access edge, the only way to clear the flag
  wire ctrl_wr;
  wire unmapped;
  assign ctrl_wr = I_PSEL && I_PENABLE && I_PWRITE && I_CE &&
    I_PADDR == ADDR_W'(OFS_INTERFACE_CONTROL);
  assign unmapped = I_PADDR > ADDR_W'(OFS_BYTE_BUFFER_REGISTER) || I_PADDR[1:0] != 2'b00;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  AST_SLVERR: assert property (I_PSEL && !I_PENABLE && I_CE && unmapped |=> O_PSLVERR)
    else $error("unmapped access without slave error");
  AST_SCL_HOLD: assert property (O_SCL_OE && !ctrl_wr |=> O_SCL_OE)
    else $error("scl released without flag clear");
  AST_ACK_EXCL: assert property (!(O_SDA_OE && O_SCL_OE))
    else $error("ack driven while scl stretched");
  AST_ACK_SCL_LOW: assert property ($rose(O_SDA_OE) |-> !I_SCL_IN)
    else $error("ack started while scl high");
  AST_ACK_LEN: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*6])
    else $error("ack pulse too short");
  AST_IRQ_CAUSE: assert property ($rose(O_IRQ) |-> $rose(O_SCL_OE) || $past(ctrl_wr))
    else $error("irq without flag set");
  AST_WAKE_SLEEP: assert property ($rose(O_WAKE) |-> $past(I_SLEEP))
    else $error("wake outside sleep");
  AST_WAKE_FALL: assert property ($fell(O_WAKE) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("wake dropped without flag clear");
  CV_ACK: cover property ($rose(O_SDA_OE));
  CV_IRQ: cover property ($rose(O_IRQ));
  CV_WAKE: cover property ($rose(O_WAKE));
endmodule

bind twslv_top twslv_props #(.ADDR_W(ADDR_W)) u_twslv_props (.I_CLK(I_CLK),
  .I_RESET(I_RESET), .I_CE(I_CE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PSLVERR(O_PSLVERR), .I_SCL_IN(I_SCL_IN),
  .I_SLEEP(I_SLEEP), .O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_WAKE(O_WAKE),
  .O_IRQ(O_IRQ));

// *** dv/twslv_mst.sv ***
// behavioural bus master transmitter facing the slave's pins
`timescale 1ns/1ns
module twslv_mst (
  // clock and wire levels
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  // high pulls the wire low
  output logic o_scl_pull,
  output logic o_sda_pull
);
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
  end
  // a third of the 96 ns bus period
  task automatic half();
    repeat (8) @(posedge i_clk);
  endtask
  // release scl, then wait while the slave stretches it
  // stretch honoured
  task automatic scl_high();
    o_scl_pull <= 1'b0;
    @(posedge i_clk);
    while (i_scl !== 1'b1) @(posedge i_clk);
    // one edge already spent above keeps the high time at 32 ns
    repeat (7) @(posedge i_clk);
  endtask
  // start or repeated start: sda falls with scl high
  task automatic start();
    o_sda_pull <= 1'b0;
    scl_high();
    o_sda_pull <= 1'b1;
    half();
    o_scl_pull <= 1'b1;
    half();
  endtask
  // msb first, sda moves only while scl low; ninth clock reads the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_pull <= ~b[i];
      half();
      scl_high();
      o_scl_pull <= 1'b1;
      half();
    end
    o_sda_pull <= 1'b0;
    half();
    scl_high();
    ack = (i_sda === 1'b0);
    o_scl_pull <= 1'b1;
    half();
  endtask
  // stop: sda rises with scl high
  task automatic stop();
    o_sda_pull <= 1'b1;
    half();
    scl_high();
    o_sda_pull <= 1'b0;
    half();
  endtask
endmodule

// *** dv/twowire_slave_receiver_tb.sv ***
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ns
module twowire_slave_receiver_tb;
  import twslv_pkg::*;
  // own address 0x29 with write bit; ctrl run = ack, enable, irq enable
  localparam logic [7:0] OWN_W = 8'h52;
  localparam logic [7:0] RUN = 8'h45;
  localparam logic [7:0] CLR = 8'hC5;
  localparam logic [7:0] CLR_NA = 8'h85;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sleep = 1'b0;
  logic arb = 1'b0;
  logic [31:0] prdata;
  logic [31:0] d;
  logic ce = 1'b1;
  logic pready, pslverr, scl_oe, sda_oe, wake, irq, err, ack, scl, sda, scl_pull, sda_pull;
  logic start_req;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // open-drain wires with pull-ups
  assign scl = ~(scl_pull | scl_oe);
  assign sda = ~(sda_pull | sda_oe);
  always #2 clk = ~clk;
  twslv_top u_twslv_top (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL_IN(scl),
    .O_SCL_OUT(), .O_SCL_OE(scl_oe), .I_SDA_IN(sda), .O_SDA_OUT(), .O_SDA_OE(sda_oe),
    .I_SLEEP(sleep), .I_ARB_LOST(arb), .O_WAKE(wake), .O_START_REQ(start_req), .O_IRQ(irq));
  twslv_mst u_twslv_mst (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_pull(scl_pull),
    .o_sda_pull(sda_pull));
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; holds everything until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0000_00, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, OFS_INTERFACE_CONTROL, v);
  endtask
  task automatic status_is(input logic [7:0] s);
    apb(1'b0, OFS_BUS_STATE_REGISTER, 8'h00);
    chk({24'h0000_00, d[7:0] & 8'hF8}, {24'h0000_00, s});
  endtask
  // one byte from the master; status checked when s is nonzero
  task automatic byte_chk(input logic [7:0] b, input logic ea, input logic [7:0] s);
    u_twslv_mst.send_byte(b, ack);
    chk({31'h0, ack}, {31'h0, ea});
    if (s != 8'h00) status_is(s);
  endtask
  // stop while addressed, then clear the flag
  task automatic stop_chk();
    u_twslv_mst.stop();
    status_is(STA_END_ADDRESSED);
    ctrl(CLR);
  endtask
  task automatic t_reset();
    apb(1'b0, OFS_OWN_SLAVE_ADDRESS, 8'h00);
    chk(d, {24'h0000_00, RST_OWN_SLAVE_ADDRESS});
    status_is(STA_NO_INFO);
    apb(1'b0, OFS_BYTE_BUFFER_REGISTER, 8'h00);
    chk(d, {24'h0000_00, RST_BYTE_BUFFER});
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h0000_0001);
    // buffer write with flag clear is dropped and flagged
    apb(1'b1, OFS_BYTE_BUFFER_REGISTER, 8'h5A);
    apb(1'b0, OFS_INTERFACE_CONTROL, 8'h00);
    chk(d, 32'h0000_0008);
    // clock enable low freezes state: this write must not land
    ce <= 1'b0;
    apb(1'b1, OFS_OWN_SLAVE_ADDRESS, 8'h11);
    ce <= 1'b1;
    apb(1'b0, OFS_OWN_SLAVE_ADDRESS, 8'h00);
    chk(d, {24'h0000_00, RST_OWN_SLAVE_ADDRESS});
    apb(1'b1, OFS_OWN_SLAVE_ADDRESS, OWN_W);
    ctrl(RUN);
    // begin request on an idle free bus raises the start request
    ctrl(RUN | 8'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, start_req}, 32'h0000_0001);
    ctrl(RUN);
    repeat (2) @(posedge clk);
    chk({31'h0, start_req}, 32'h0000_0000);
  endtask
  task automatic t_own();
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b1, STA_OWN_ADDR);
    chk({30'h0, irq, scl_oe}, 32'h0000_0003);
    ctrl(CLR);
    @(posedge clk);
    chk({31'h0, scl_oe}, 32'h0000_0000);
    byte_chk(8'hA5, 1'b1, STA_DATA_ACK);
    apb(1'b0, OFS_BYTE_BUFFER_REGISTER, 8'h00);
    chk(d, 32'h0000_00A5);
    ctrl(CLR);
    stop_chk();
  endtask
  task automatic t_nack();
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b1, STA_OWN_ADDR);
    ctrl(CLR_NA);
    byte_chk(8'h3C, 1'b0, STA_DATA_NACK);
    ctrl(CLR_NA);
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b0, 8'h00);
    u_twslv_mst.stop();
    ctrl(RUN);
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b1, STA_OWN_ADDR);
    ctrl(CLR);
    stop_chk();
  endtask
  task automatic t_bcast();
    u_twslv_mst.start();
    byte_chk(OWN_W | 8'h01, 1'b0, 8'h00);
    u_twslv_mst.start();
    byte_chk(BROADCAST_ADDRESS, 1'b0, 8'h00);
    u_twslv_mst.stop();
    apb(1'b1, OFS_OWN_SLAVE_ADDRESS, OWN_W | 8'h01);
    u_twslv_mst.start();
    byte_chk(BROADCAST_ADDRESS, 1'b1, STA_GEN_CALL);
    ctrl(CLR);
    byte_chk(8'h77, 1'b1, STA_GC_DATA_ACK);
    ctrl(CLR);
    stop_chk();
  endtask
  task automatic t_arb();
    arb <= 1'b1;
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b1, STA_OWN_ADDR_ARB);
    ctrl(CLR);
    stop_chk();
    u_twslv_mst.start();
    byte_chk(BROADCAST_ADDRESS, 1'b1, STA_GEN_CALL_ARB);
    ctrl(CLR);
    stop_chk();
    arb <= 1'b0;
  endtask
  task automatic t_sleep();
    sleep <= 1'b1;
    u_twslv_mst.start();
    byte_chk(OWN_W, 1'b1, STA_OWN_ADDR);
    chk({30'h0, wake, scl_oe}, 32'h0000_0003);
    sleep <= 1'b0;
    ctrl(CLR);
    repeat (2) @(posedge clk);
    chk({30'h0, wake, scl_oe}, 32'h0000_0000);
    byte_chk(8'hC3, 1'b1, STA_DATA_ACK);
    // a byte taken while asleep leaves the buffer untouched
    sleep <= 1'b1;
    ctrl(CLR);
    byte_chk(8'h96, 1'b1, STA_DATA_ACK);
    apb(1'b0, OFS_BYTE_BUFFER_REGISTER, 8'h00);
    chk(d, 32'h0000_00C3);
    sleep <= 1'b0;
    ctrl(CLR);
    stop_chk();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_own();
    t_nack();
    t_bcast();
    t_arb();
    t_sleep();
    give_verdict();
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
